/* File: rtl/sld_pkg.sv */
// Package: constants, states and carriers of the serial LED sink driver
`default_nettype none
package sld_pkg;

   // Default geometry
   localparam int CHANNELS_DEF   = 16;
   localparam int FIFO_DEPTH_DEF = 8;

   // Values after reset
   localparam logic       SYNC_RST = 1'b0;
   localparam logic       SOUT_RST = 1'b0;
   localparam logic [3:0] CNT_RST  = 4'h0;

   // Shift clock limit of the controller (cascade), in Hz
   localparam int SHIFT_CLK_MAX_HZ = 20_000_000;

   // System clock rate and period
   localparam int SYS_CLK_HZ    = 50_000_000;
   localparam int SYS_PERIOD_NS = 20;

   // Least blank-low pulse the controller keeps, in ns
   localparam int BLANK_LOW_HI_NS = 2000;
   localparam int BLANK_LOW_LO_NS = 3000;
   localparam int BLANK_LOW_HI_CYC = (BLANK_LOW_HI_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int BLANK_LOW_LO_CYC = (BLANK_LOW_LO_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

   // Shift engine states, one-hot
   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b01,
      ST_SHIFT = 2'b10
   } sld_state_e;

   // Pin levels as sampled from the controller
   typedef struct packed
   {
      logic serial_in;
      logic shift_clk;
      logic load_strobe;
      logic blank;
   } sld_pins_s;

   localparam sld_pins_s PINS_RST = '{default: 1'b0};

endpackage
`default_nettype wire

/* File: rtl/sld_driver.sv */
// Serial-in parallel-out LED sink driver with sampled pins and bit FIFO
`default_nettype none

// FIFO of flip-flops, WIDTH by DEPTH, valid and ready on both sides
module sld_fifo
#(
   parameter int WIDTH = 1,
   parameter int DEPTH = sld_pkg::FIFO_DEPTH_DEF
)
(
   input  wire logic             sys_clk,
   input  wire logic             reset_n,
   input  wire logic             clk_en,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // Refuse shapes the pointer logic cannot serve
   if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_bad
      $error("sld_fifo: WIDTH >= 1 and DEPTH a power of two >= 2 needed");
   end

   logic [WIDTH-1:0] mem      [DEPTH];
   logic [WIDTH-1:0] next_mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [AW:0]      next_wr_ptr;
   logic [AW:0]      next_rd_ptr;
   logic             push;
   logic             pop;

   // Full when pointers differ only in the wrap bit
   assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign out_valid = (wr_ptr != rd_ptr);
   assign out_data  = mem[rd_ptr[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Next storage and pointers
   always_comb
   begin
      next_mem    = mem;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      if (push)
      begin
         next_mem[wr_ptr[AW-1:0]] = in_data;
         next_wr_ptr              = wr_ptr + 1'b1;
      end
      if (pop)
      begin
         next_rd_ptr = rd_ptr + 1'b1;
      end
   end

   // Register storage and pointers
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         mem    <= '{default: '0};
      end
      else if (clk_en)
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         mem    <= next_mem;
      end
   end
endmodule

module sld_driver
#(
   parameter int CHANNELS   = sld_pkg::CHANNELS_DEF,
   parameter int FIFO_DEPTH = sld_pkg::FIFO_DEPTH_DEF
)
(
   input  wire logic                sys_clk,
   input  wire logic                reset_n,
   input  wire logic                clk_en,
   input  wire logic                serial_in,
   input  wire logic                shift_clk,
   input  wire logic                load_strobe,
   input  wire logic                blank,
   output logic      [CHANNELS-1:0] sink_outputs,
   output logic                     serial_out,
   output logic                     capture_ready,
   output logic                     capture_overrun
);
   // Refuse a register too short to shift through
   if (CHANNELS < 2)
   begin : g_bad
      $error("sld_driver: CHANNELS must be at least 2");
   end

   // Refuse a queue depth the pointer logic cannot serve
   if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
   begin : g_bad_depth
      $error("sld_driver: FIFO_DEPTH must be a power of two, at least 2");
   end

   // Rising edge of a sampled level
   function automatic logic sld_rise(input logic prev, input logic cur);
      return cur && !prev;
   endfunction

   // Next shift register: newest bit at stage 0
   function automatic logic [CHANNELS-1:0] sld_shift(input logic [CHANNELS-1:0] sr,
                                                     input logic bit_in);
      return {sr[CHANNELS-2:0], bit_in};
   endfunction

   sld_pkg::sld_pins_s  pins_in;
   sld_pkg::sld_pins_s  pins_meta;
   sld_pkg::sld_pins_s  pins_sync;
   logic                clk_prev;
   logic                next_clk_prev;
   logic                edge_seen;

   logic                fifo_in_ready;
   logic                fifo_out_valid;
   logic                fifo_out_ready;
   logic [0:0]          fifo_out_data;

   sld_pkg::sld_state_e state;
   sld_pkg::sld_state_e next_state;
   logic                held_bit;
   logic                next_held_bit;
   logic [CHANNELS-1:0] shift_reg;
   logic [CHANNELS-1:0] next_shift_reg;

   logic [CHANNELS-1:0] latch_q;
   logic [CHANNELS-1:0] next_latch_q;
   logic [CHANNELS-1:0] next_sink_outputs;
   logic                next_serial_out;
   logic                next_capture_ready;
   logic                next_capture_overrun;

   assign pins_in = '{serial_in: serial_in, shift_clk: shift_clk,
                      load_strobe: load_strobe, blank: blank};

   // Two-stage synchronisers for every controller pin
   // Logic reads only the second stage; the first may go metastable
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         pins_meta <= sld_pkg::PINS_RST;
         pins_sync <= sld_pkg::PINS_RST;
      end
      else if (clk_en)
      begin
         pins_meta <= pins_in;
         pins_sync <= pins_meta;
      end
   end

   // Edge detector on the synchronised shift clock
   // Reset level equals the idle low clock, so no false edge follows reset
   always_comb
   begin
      next_clk_prev = pins_sync.shift_clk;
      edge_seen     = sld_rise(clk_prev, pins_sync.shift_clk);
   end

   // Register the previous shift clock level
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         clk_prev <= sld_pkg::SYNC_RST;
      end
      else if (clk_en)
      begin
         clk_prev <= next_clk_prev;
      end
   end

   // Captured bits queue up in order of their shift clock edges
   // Depth only bridges bursts; the engine drains one bit every two cycles
   sld_fifo
   #(
      .WIDTH (1),
      .DEPTH (FIFO_DEPTH)
   )
   u_fifo
   (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .clk_en    (clk_en),
      .in_valid  (edge_seen),
      .in_ready  (fifo_in_ready),
      .in_data   (pins_sync.serial_in),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // Shift engine: pop one bit, then commit it to the register
   always_comb
   begin
      next_state     = state;
      next_held_bit  = held_bit;
      next_shift_reg = shift_reg;
      fifo_out_ready = 1'b0;
      case (state)
         sld_pkg::ST_IDLE:
         begin
            if (fifo_out_valid)
            begin
               fifo_out_ready = 1'b1;
               next_held_bit  = fifo_out_data[0];
               next_state     = sld_pkg::ST_SHIFT;
            end
         end
         sld_pkg::ST_SHIFT:
         begin
            next_shift_reg = sld_shift(shift_reg, held_bit);
            next_state     = sld_pkg::ST_IDLE;
         end
         default:
         begin
            next_state = sld_pkg::ST_IDLE;
         end
      endcase
   end

   // Register the shift engine
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         state     <= sld_pkg::ST_IDLE;
         held_bit  <= sld_pkg::SOUT_RST;
         shift_reg <= '0;
      end
      else if (clk_en)
      begin
         state     <= next_state;
         held_bit  <= next_held_bit;
         shift_reg <= next_shift_reg;
      end
   end

   // Level latch, output gating and serial cascade output
   always_comb
   begin
      next_latch_q = latch_q;
      if (pins_sync.load_strobe)
      begin
         next_latch_q = shift_reg;
      end
      // Strobe low keeps the latch as is
      next_sink_outputs    = pins_sync.blank ? '0 : latch_q;
      next_serial_out      = shift_reg[CHANNELS-1];
      next_capture_ready   = fifo_in_ready;
      // Legal pin rates never fill the queue; a set flag means a too-fast controller
      next_capture_overrun = capture_overrun || (edge_seen && !fifo_in_ready);
   end

   // Register latch and outputs; every top output comes from here
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         latch_q         <= '0;
         sink_outputs    <= '0;
         serial_out      <= sld_pkg::SOUT_RST;
         capture_ready   <= 1'b0;
         capture_overrun <= 1'b0;
      end
      else if (clk_en)
      begin
         latch_q         <= next_latch_q;
         sink_outputs    <= next_sink_outputs;
         serial_out      <= next_serial_out;
         capture_ready   <= next_capture_ready;
         capture_overrun <= next_capture_overrun;
      end
   end
endmodule
`default_nettype wire

/* File: verif/sld_checker.sv */
// Port checker of the LED sink driver
`default_nettype none
module sld_checker
#(
   parameter int CHANNELS = 16
)
(
   input wire logic                sys_clk,
   input wire logic                reset_n,
   input wire logic                clk_en,
   input wire logic                shift_clk,
   input wire logic                load_strobe,
   input wire logic                blank,
   input wire logic [CHANNELS-1:0] sink_outputs,
   input wire logic                serial_out,
   input wire logic                capture_ready,
   input wire logic                capture_overrun
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   // Port properties
   property p_rst;
      $rose(reset_n) |-> sink_outputs == '0 && !serial_out && !capture_overrun;
   endproperty
   property p_rdy;
      $rose(reset_n) && clk_en |=> capture_ready;
   endproperty
   property p_blank;
      (blank && clk_en) [*5] |-> sink_outputs == '0;
   endproperty
   property p_hold;
      (!load_strobe && !blank && clk_en) [*6] |-> $stable(sink_outputs);
   endproperty
   property p_sout;
      (!shift_clk) [*8] |-> $stable(serial_out);
   endproperty
   property p_freeze;
      !clk_en |=> $stable(sink_outputs) && $stable(serial_out);
   endproperty
   property p_sticky;
      capture_overrun |=> capture_overrun;
   endproperty
   property p_step;
      $changed(serial_out) |=> $stable(serial_out);
   endproperty
   a_rst: assert property (p_rst) else $error("Outputs not clear at reset release");
   a_rdy: assert property (p_rdy) else $error("Capture not ready after reset");
   a_blank: assert property (p_blank) else $error("Output on while blanked");
   a_hold: assert property (p_hold) else $error("Outputs moved with strobe low");
   a_sout: assert property (p_sout) else $error("Serial out moved without clock");
   a_freeze: assert property (p_freeze) else $error("Outputs moved while frozen");
   a_sticky: assert property (p_sticky) else $error("Overrun flag dropped");
   a_step: assert property (p_step) else $error("Two shifts in two cycles");
   c_blank: cover property (blank [*5]);
   c_freeze: cover property (!clk_en);
   c_change: cover property ($changed(sink_outputs));
endmodule
bind sld_driver sld_checker #(.CHANNELS(CHANNELS)) i_sld_checker
(
   .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .shift_clk(shift_clk),
   .load_strobe(load_strobe), .blank(blank), .sink_outputs(sink_outputs),
   .serial_out(serial_out), .capture_ready(capture_ready),
   .capture_overrun(capture_overrun)
);
`default_nettype wire

/* File: verif/sld_ctrl_model.sv */
// Display controller model driving the sink driver pins
`default_nettype none
module sld_ctrl_model
(
   input  wire logic sys_clk,
   output logic      serial_in,
   output logic      shift_clk,
   output logic      load_strobe,
   output logic      blank
);
   timeunit 1ns;
   timeprecision 1ps;

   // Pins idle with outputs enabled and latch holding
   initial
   begin
      serial_in = 1'b0;
      shift_clk = 1'b0;
      load_strobe = 1'b0;
      blank = 1'b0;
   end

   // Wait n edges, then step just past the edge
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask

   // One bit: slow clock, data held round the rise, then inverted data
   task automatic send_bit(input logic b);
      serial_in = b;
      tick(3);
      shift_clk = 1'b1;
      tick(3);
      shift_clk = 1'b0;
      serial_in = ~b;
      tick(3);
   endtask

   // Whole frame, farthest output first, strobe left alone
   task automatic send_frame(input logic [15:0] v);
      for (int i = 15; i >= 0; i--)
         send_bit(v[i]);
   endtask

   // Strobe level change
   task automatic set_strobe(input logic s);
      load_strobe = s;
      tick(3);
   endtask

   // Blank level; a low pulse is kept at least its least width
   task automatic set_blank(input logic v);
      blank = v;
      tick(v ? 3 : sld_pkg::BLANK_LOW_LO_CYC);
   endtask
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench of the LED sink driver
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        sys_clk;
   logic        reset_n;
   logic        clk_en;
   logic        serial_in;
   logic        shift_clk;
   logic        load_strobe;
   logic        blank;
   logic [15:0] sink_outputs;
   logic        serial_out;
   logic        capture_ready;
   logic        capture_overrun;
   logic [18:0] expq[$];
   logic [31:0] seed;
   logic [15:0] f;
   logic [15:0] g;
   int          err_total;
   int          checked;
   int          cycles;
   event        look;

   sld_driver i_sld_driver
   (
      .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .serial_in(serial_in),
      .shift_clk(shift_clk), .load_strobe(load_strobe), .blank(blank),
      .sink_outputs(sink_outputs), .serial_out(serial_out),
      .capture_ready(capture_ready), .capture_overrun(capture_overrun)
   );
   sld_ctrl_model i_sld_ctrl_model
   (
      .sys_clk(sys_clk), .serial_in(serial_in), .shift_clk(shift_clk),
      .load_strobe(load_strobe), .blank(blank)
   );

   // Clock source
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // Xorshift source
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Verdict and end of run
   task automatic wrap_up();
      $display("checked=%0d err_total=%0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Let outputs settle, then note the expected outputs
   task automatic note(input logic [16:0] e);
      i_sld_ctrl_model.tick(12);
      // Queue stays ready and never overruns at legal pin rates
      expq.push_back({e, 2'b10});
      ->look;
   endtask

   // Compare outputs with the oldest note
   initial
   begin
      logic [18:0] e;
      forever
      begin
         @(look);
         e = expq.pop_front();
         checked++;
         if ({sink_outputs, serial_out, capture_ready, capture_overrun} !== e)
         begin
            $display("BAD t=%0t exp=%h got=%h", $time, e,
                     {sink_outputs, serial_out, capture_ready, capture_overrun});
            err_total++;
         end
      end
   end

   // Hang guard
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_total++;
         wrap_up();
      end
   end

   // Main sequence
   initial
   begin
      seed = 32'h0000004e;
      err_total = 0;
      checked = 0;
      cycles = 0;
      clk_en = 1'b1;
      reset_n = 1'b0;
      repeat (12) @(posedge sys_clk);
      #2 reset_n = 1'b1;
      f = 16'(rnd());
      g = 16'(rnd());
      i_sld_ctrl_model.send_frame(f);
      note({16'h0000, f[15]});
      i_sld_ctrl_model.set_strobe(1'b1);
      note({f, f[15]});
      i_sld_ctrl_model.set_blank(1'b1);
      note({16'h0000, f[15]});
      i_sld_ctrl_model.set_strobe(1'b0);
      i_sld_ctrl_model.set_blank(1'b0);
      note({f, f[15]});
      i_sld_ctrl_model.send_frame(g);
      note({f, g[15]});
      i_sld_ctrl_model.set_strobe(1'b1);
      i_sld_ctrl_model.send_bit(f[0]);
      note({g[14:0], f[0], g[14]});
      clk_en = 1'b0;
      i_sld_ctrl_model.set_blank(1'b1);
      note({g[14:0], f[0], g[14]});
      clk_en = 1'b1;
      note({16'h0000, g[14]});
      i_sld_ctrl_model.set_blank(1'b0);
      note({g[14:0], f[0], g[14]});
      wrap_up();
   end
endmodule
`default_nettype wire
